//--- logic/cih_pkg.sv
// Constants shared by the card task-file host port and its strobe engine.
// Assumes a 100 MHz system clock and a card in true IDE mode, PIO mode 0.
package cih_pkg;

   // ************************************************************
   // Control port word offsets
   // ************************************************************
   localparam logic [1:0] CTL_CARD_CONTROL = 2'h0;
   localparam logic [1:0] CTL_IRQ_GATE     = 2'h1;
   localparam logic [1:0] CTL_RSVD_A       = 2'h2;
   localparam logic [1:0] CTL_RSVD_B       = 2'h3;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int BIT_PRESENT        = 0;
   localparam int BIT_POWER          = 1;
   localparam int BIT_RESET          = 2;
   localparam int BIT_PRESENCE_IRQEN = 3;
   localparam int BIT_CARD_IRQEN     = 0;
   localparam logic RST_POWER          = 1'b0;
   localparam logic RST_CARD_RESET     = 1'b1;
   localparam logic RST_PRESENCE_IRQEN = 1'b0;
   localparam logic RST_CARD_IRQEN     = 1'b0;

   // ************************************************************
   // Task-file offsets
   // ************************************************************
   localparam logic [3:0] TF_LAST_CMD_BLOCK = 4'h7;
   localparam logic [3:0] TF_ALT_STATUS     = 4'he;

   // ************************************************************
   // PIO mode 0 timing, ns, and cycles at 100 MHz
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS    = 70;  // Address valid to strobe
   localparam int T_PULSE_NS    = 165; // Strobe active width
   localparam int T_RECOV_NS    = 435; // Rest of the 670 ns cycle
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   typedef enum {
      CIH_IDLE,
      CIH_SETUP,
      CIH_PULSE,
      CIH_RECOV
   } cih_state_t;

endpackage : cih_pkg

//--- logic/cih_strobe.sv
// PIO mode 0 strobe engine for one task-file access at a time.
// Assumes a request pulse from the main module only while not busy.
`timescale 1ns/1ps
`default_nettype none
module cih_strobe (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   input  wire logic                start_i,
   input  wire logic                write_i,
   input  wire logic [3:0]          addr_i,
   input  wire logic [15:0]         wdata_i,
   input  wire logic [15:0]         card_data_i,
   output logic                     busy_o,
   output logic                     done_o,
   output logic [15:0]              rdata_o,
   output logic [2:0]               card_addr_o,
   output logic [1:0]               card_cs_n_o,
   output logic                     card_rd_n_o,
   output logic                     card_wr_n_o,
   output logic [15:0]              card_data_o,
   output logic                     card_data_oe_o
);
   import cih_pkg::*;

   cih_state_t        state_ff, nxt_state;
   logic [CNT_W-1:0]  cnt_ff;
   logic              wr_ff;
   logic              cnt_zero;
   logic              alt_blk;
   logic [15:0]       din_meta_ff;
   logic [15:0]       din_ff;

   assign cnt_zero = (cnt_ff == '0);
   assign alt_blk  = (addr_i > TF_LAST_CMD_BLOCK);

   // Card data bus, two stages before use
   // Pulse lasts well over two cycles, so din_ff is read-strobe data
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         din_meta_ff <= 16'h0000;
         din_ff      <= 16'h0000;
      end else if (ce_i) begin
         din_meta_ff <= card_data_i;
         din_ff      <= din_meta_ff;
      end
   end

   // Phase sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CIH_IDLE:  if (start_i) nxt_state = CIH_SETUP;
         CIH_SETUP: if (cnt_zero) nxt_state = CIH_PULSE;
         CIH_PULSE: if (cnt_zero) nxt_state = CIH_RECOV;
         CIH_RECOV: if (cnt_zero) nxt_state = CIH_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff       <= CIH_IDLE;
         cnt_ff         <= '0;
         wr_ff          <= 1'b0;
         done_o         <= 1'b0;
         rdata_o        <= 16'h0000;
         card_addr_o    <= 3'h0;
         card_cs_n_o    <= 2'h3;
         card_rd_n_o    <= 1'b1;
         card_wr_n_o    <= 1'b1;
         card_data_o    <= 16'h0000;
         card_data_oe_o <= 1'b0;
         busy_o         <= 1'b0;
      end else if (ce_i) begin
         state_ff <= nxt_state;
         done_o   <= 1'b0;
         if (!cnt_zero) cnt_ff <= cnt_ff - 1'b1;
         unique case (state_ff)
            CIH_IDLE: if (start_i) begin
               busy_o         <= 1'b1;
               wr_ff          <= write_i;
               cnt_ff         <= CNT_W'(SETUP_CYC - 1);
               card_addr_o    <= addr_i[2:0];
               card_cs_n_o    <= alt_blk ? 2'h1 : 2'h2;
               card_data_o    <= wdata_i;
               card_data_oe_o <= write_i;
            end
            CIH_SETUP: if (cnt_zero) begin
               cnt_ff      <= CNT_W'(PULSE_CYC - 1);
               card_rd_n_o <= wr_ff;
               card_wr_n_o <= !wr_ff;
            end
            CIH_PULSE: if (cnt_zero) begin
               cnt_ff      <= CNT_W'(RECOV_CYC - 1);
               card_rd_n_o <= 1'b1;
               card_wr_n_o <= 1'b1;
               if (!wr_ff) rdata_o <= din_ff;
               done_o      <= 1'b1;
            end
            CIH_RECOV: if (cnt_zero) begin
               busy_o         <= 1'b0;
               card_cs_n_o    <= 2'h3;
               card_data_oe_o <= 1'b0;
            end
         endcase
      end
   end
endmodule : cih_strobe
`default_nettype wire

//--- logic/cih_host_port.sv
// Card IDE host port: task-file pass-through plus control registers.
// Assumes agent requests held until waitrequest drops; card pins async.
`timescale 1ns/1ps
`default_nettype none
module cih_host_port (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Task-file agent port
   input  wire logic [3:0]  tf_address_i,
   input  wire logic        tf_read_i,
   input  wire logic        tf_write_i,
   input  wire logic [15:0] tf_writedata_i,
   output logic [15:0]      tf_readdata_o,
   output logic             tf_waitrequest_o,
   // Control agent port
   input  wire logic [1:0]  ctl_address_i,
   input  wire logic        ctl_read_i,
   input  wire logic        ctl_write_i,
   input  wire logic [31:0] ctl_writedata_i,
   output logic [31:0]      ctl_readdata_o,
   // Interrupts
   output logic             presence_irq_o,
   output logic             card_irq_o,
   // Card pins
   output logic [2:0]       card_addr_o,
   output logic [1:0]       card_cs_n_o,
   output logic             card_rd_n_o,
   output logic             card_wr_n_o,
   input  wire logic [15:0] card_data_i,
   output logic [15:0]      card_data_o,
   output logic             card_data_oe_o,
   input  wire logic        card_detect_i,
   input  wire logic        card_intrq_i,
   output logic             card_power_o,
   output logic             card_reset_n_o
);
   import cih_pkg::*;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] det_sync_ff;
   logic [1:0] irq_sync_ff;
   logic       det_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         det_sync_ff <= 2'h0;
         irq_sync_ff <= 2'h0;
         det_ff      <= 1'b0;
      end else if (ce_i) begin
         det_sync_ff <= {det_sync_ff[0], card_detect_i};
         irq_sync_ff <= {irq_sync_ff[0], card_intrq_i};
         det_ff      <= det_sync_ff[1];
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   logic card_power_on_ff;
   logic card_reset_ff;
   logic presence_irq_enable_ff;
   logic card_irq_enable_ff;
   logic presence_pend_ff;
   logic card_pend_ff;

   // Control port decode
   wire ctl_wr_cc   = ctl_write_i && (ctl_address_i == CTL_CARD_CONTROL);
   wire ctl_wr_gate = ctl_write_i && (ctl_address_i == CTL_IRQ_GATE);
   wire ctl_rd_cc   = ctl_read_i && (ctl_address_i == CTL_CARD_CONTROL);
   wire det_change  = (det_ff != det_sync_ff[1]);

   wire [31:0] cc_word = {28'h0000000, presence_irq_enable_ff, card_reset_ff,
                          card_power_on_ff, det_ff};
   wire [31:0] gate_word = {31'h00000000, card_irq_enable_ff};
   wire [31:0] ctl_rmux =
      (ctl_address_i == CTL_CARD_CONTROL) ? cc_word :
      (ctl_address_i == CTL_IRQ_GATE)     ? gate_word : 32'h00000000;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         card_power_on_ff       <= RST_POWER;
         card_reset_ff          <= RST_CARD_RESET;
         presence_irq_enable_ff <= RST_PRESENCE_IRQEN;
      end else if (ce_i && ctl_wr_cc) begin
         card_power_on_ff       <= ctl_writedata_i[BIT_POWER];
         card_reset_ff          <= ctl_writedata_i[BIT_RESET];
         presence_irq_enable_ff <= ctl_writedata_i[BIT_PRESENCE_IRQEN];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         card_irq_enable_ff <= RST_CARD_IRQEN;
      end else if (ce_i && ctl_wr_gate) begin
         card_irq_enable_ff <= ctl_writedata_i[BIT_CARD_IRQEN];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_readdata_o <= 32'h00000000;
      end else if (ce_i) begin
         ctl_readdata_o <= ctl_rmux;
      end
   end

   // ************************************************************
   // Interrupt requests
   // ************************************************************
   wire nxt_presence_pend = (presence_irq_enable_ff && det_change) ||
                            (presence_pend_ff && !ctl_rd_cc);
   wire nxt_card_pend     = (card_irq_enable_ff && irq_sync_ff[1]) ||
                            (card_pend_ff && !ctl_rd_cc);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presence_pend_ff <= 1'b0;
         card_pend_ff     <= 1'b0;
      end else if (ce_i) begin
         presence_pend_ff <= nxt_presence_pend;
         card_pend_ff     <= nxt_card_pend;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presence_irq_o <= 1'b0;
         card_irq_o     <= 1'b0;
      end else if (ce_i) begin
         presence_irq_o <= nxt_presence_pend;
         card_irq_o     <= nxt_card_pend && card_irq_enable_ff;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         card_power_o   <= 1'b0;
         card_reset_n_o <= 1'b0;
      end else if (ce_i) begin
         card_power_o   <= card_power_on_ff;
         card_reset_n_o <= !card_reset_ff;
      end
   end

   // ************************************************************
   // Task-file pass-through
   // ************************************************************
   logic        st_busy;
   logic        st_done;
   logic [15:0] st_rdata;
   logic        tf_active_ff;
   logic        tf_ack_ff;

   wire tf_mapped = (tf_address_i <= TF_LAST_CMD_BLOCK) ||
                    (tf_address_i == TF_ALT_STATUS);
   wire tf_req    = tf_read_i || tf_write_i;
   wire tf_start  = tf_req && tf_mapped && !tf_active_ff && !tf_ack_ff &&
                    !st_busy;
   wire tf_drop   = tf_req && !tf_mapped && !tf_active_ff && !tf_ack_ff;

   cih_strobe u_strobe (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .start_i        (tf_start),
      .write_i        (tf_write_i),
      .addr_i         (tf_address_i),
      .wdata_i        (tf_writedata_i),
      .card_data_i    (card_data_i),
      .busy_o         (st_busy),
      .done_o         (st_done),
      .rdata_o        (st_rdata),
      .card_addr_o    (card_addr_o),
      .card_cs_n_o    (card_cs_n_o),
      .card_rd_n_o    (card_rd_n_o),
      .card_wr_n_o    (card_wr_n_o),
      .card_data_o    (card_data_o),
      .card_data_oe_o (card_data_oe_o)
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tf_active_ff <= 1'b0;
         tf_ack_ff    <= 1'b0;
      end else if (ce_i) begin
         tf_ack_ff <= 1'b0;
         if (tf_start) tf_active_ff <= 1'b1;
         if ((tf_active_ff && st_done) || tf_drop) begin
            tf_active_ff <= 1'b0;
            tf_ack_ff    <= 1'b1;
         end
      end
   end

   // Wait request and read data
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tf_waitrequest_o <= 1'b1;
         tf_readdata_o    <= 16'h0000;
      end else if (ce_i) begin
         tf_waitrequest_o <= !((tf_active_ff && st_done) || tf_drop);
         if (tf_active_ff && st_done) tf_readdata_o <= st_rdata;
         else if (tf_drop) tf_readdata_o <= 16'h0000;
      end
   end

endmodule : cih_host_port
`default_nettype wire

//--- testbench/cih_host_port_properties.sv
// Checker on the card host port top-level pins.
// Assumes nothing is checked while ce_i is low.
`timescale 1ns/1ps
`default_nettype none
module cih_host_port_properties
   import cih_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic [1:0]  ctl_address_i,
   input wire logic        ctl_read_i,
   input wire logic        ctl_write_i,
   input wire logic [31:0] ctl_writedata_i,
   input wire logic [31:0] ctl_readdata_o,
   input wire logic        tf_waitrequest_o,
   input wire logic        presence_irq_o,
   input wire logic        card_irq_o,
   input wire logic [1:0]  card_cs_n_o,
   input wire logic        card_rd_n_o,
   input wire logic        card_wr_n_o,
   input wire logic        card_detect_i,
   input wire logic        card_intrq_i,
   input wire logic        card_power_o
);
   logic [2:0] quiet_ff;
   logic       gate_ff;
   logic       pen_ff;

   // Steady-pin counter and shadow copies of the enables
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         quiet_ff <= 3'h0;
         gate_ff  <= 1'b0;
         pen_ff   <= 1'b0;
      end else begin
         if ($changed(card_detect_i) || $changed(card_intrq_i))
            quiet_ff <= 3'h0;
         else if (ce_i && quiet_ff != 3'h7)
            quiet_ff <= quiet_ff + 3'h1;
         if (ce_i && ctl_write_i && ctl_address_i == CTL_IRQ_GATE)
            gate_ff <= ctl_writedata_i[BIT_CARD_IRQEN];
         if (ce_i && ctl_write_i && ctl_address_i == CTL_CARD_CONTROL)
            pen_ff <= ctl_writedata_i[BIT_PRESENCE_IRQEN];
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   // Control write followed by a quiet cycle
   sequence s_cc_hold;
      ctl_write_i && ctl_address_i == CTL_CARD_CONTROL ##1 !ctl_write_i;
   endsequence

   AST_WAIT_PULSE:
      assert property (!tf_waitrequest_o |=> tf_waitrequest_o)
      else $error("waitrequest low too long");
   AST_STROBE_CS:
      assert property (!card_rd_n_o || !card_wr_n_o |->
         card_cs_n_o != 2'b11 && (card_rd_n_o || card_wr_n_o))
      else $error("strobe without select");
   AST_POWER:
      assert property (s_cc_hold |=>
         card_power_o == $past(ctl_writedata_i[BIT_POWER], 2))
      else $error("power pin wrong");
   AST_RSVD_ZERO:
      assert property (ctl_address_i[1] |=> ctl_readdata_o == 32'h0)
      else $error("reserved offset nonzero");
   AST_GATE_READ:
      assert property (ctl_address_i == CTL_IRQ_GATE |=>
         ctl_readdata_o == {31'h0, $past(gate_ff)})
      else $error("gate readback wrong");
   AST_PRES_IRQ:
      assert property (pen_ff && $changed(card_detect_i) |->
         ##[1:6] presence_irq_o)
      else $error("presence irq missing");
   AST_CARD_IRQ:
      assert property (gate_ff && quiet_ff == 3'h7 && card_intrq_i |->
         ##[0:3] card_irq_o)
      else $error("card irq missing");
   AST_READ_CLEAR:
      assert property (ctl_read_i && ctl_address_i == CTL_CARD_CONTROL &&
         quiet_ff == 3'h7 && !card_intrq_i |=> !presence_irq_o && !card_irq_o)
      else $error("irq not cleared by read");
endmodule : cih_host_port_properties

bind cih_host_port cih_host_port_properties u_props (.*);
`default_nettype wire

//--- testbench/cih_card_model.sv
// Behavioural card in true IDE mode on the strobe pins.
// Assumes cs_n bit 1 low selects the alternate block.
`timescale 1ns/1ps
`default_nettype none
module cih_card_model #(
   parameter logic [15:0] STATUS_VAL = 16'h0050
) (
   input  wire logic        clk_i,
   input  wire logic [2:0]  card_addr_i,
   input  wire logic [1:0]  card_cs_n_i,
   input  wire logic        card_rd_n_i,
   input  wire logic        card_wr_n_i,
   input  wire logic        card_reset_n_i,
   input  wire logic [15:0] host_data_i,
   input  wire logic        host_oe_i,
   output logic      [15:0] bus_o,
   output logic      [15:0] devctl_o
);
   logic [15:0] regs_ff [0:15];
   logic [15:0] last_ff;
   logic [3:0]  idx;
   logic        sel;

   // register select, status at 7 and 14
   assign sel = card_cs_n_i != 2'b11;
   assign idx = !card_cs_n_i[1] ? 4'he : {1'b0, card_addr_i};
   // data only while read strobe low
   assign bus_o = host_oe_i ? host_data_i : (sel && !card_rd_n_i) ?
      ((idx == 4'h7 || idx == 4'he) ? STATUS_VAL : regs_ff[idx]) : ~last_ff;
   assign devctl_o = regs_ff[14];

   initial last_ff = 16'h0;
   // capture data while write strobe low
   always @(posedge clk_i) begin
      last_ff <= bus_o;
      if (sel && !card_wr_n_i && card_reset_n_i)
         regs_ff[idx] <= host_data_i;
   end
endmodule : cih_card_model
`default_nettype wire

//--- testbench/cih_host_port_tb_top.sv
// Self-checking bench for the card host port with a card model.
// Assumes the checker binds itself; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module cih_host_port_tb_top;
   import cih_pkg::*;
   typedef struct {
      logic [1:0]  a;
      logic [31:0] wd;
      logic [31:0] rd;
      logic [1:0]  pins;
   } cih_row_t;
   localparam logic [15:0] ST = 16'h0050;
   logic        clk_i, rst_i, ce_i, tf_read_i, tf_write_i, ctl_read_i;
   logic        ctl_write_i, card_detect_i, card_intrq_i, tf_waitrequest_o;
   logic        presence_irq_o, card_irq_o, card_rd_n_o, card_wr_n_o;
   logic        card_data_oe_o, card_power_o, card_reset_n_o;
   logic [3:0]  tf_address_i, a;
   logic [1:0]  ctl_address_i, card_cs_n_o;
   logic [2:0]  card_addr_o;
   logic [15:0] tf_writedata_i, tf_readdata_o, card_data_i, card_data_o;
   logic [15:0] devctl;
   logic [31:0] ctl_writedata_i, ctl_readdata_o, v;
   int          failures, checked;
   cih_row_t    rows [6] = '{
      '{2'h0, 32'hffff_fffe, 32'h0000_000f, 2'h2},
      '{2'h1, 32'hffff_ffff, 32'h0000_0001, 2'h2},
      '{2'h2, 32'hffff_ffff, 32'h0000_0000, 2'h2},
      '{2'h3, 32'hffff_ffff, 32'h0000_0000, 2'h2},
      '{2'h1, 32'h0000_0000, 32'h0000_0000, 2'h2},
      '{2'h0, 32'h0000_0002, 32'h0000_0003, 2'h3}};

   cih_host_port DUT (.*);
   cih_card_model #(.STATUS_VAL(ST)) u_card (
      .clk_i(clk_i), .card_addr_i(card_addr_o), .card_cs_n_i(card_cs_n_o),
      .card_rd_n_i(card_rd_n_o), .card_wr_n_i(card_wr_n_o),
      .card_reset_n_i(card_reset_n_o), .host_data_i(card_data_o),
      .host_oe_i(card_data_oe_o), .bus_o(card_data_i), .devctl_o(devctl));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic ctl(input logic w, input logic [1:0] ad, input logic [31:0] d);
      @(negedge clk_i);
      ctl_address_i = ad;
      ctl_writedata_i = d;
      ctl_write_i = w;
      ctl_read_i = !w;
      @(negedge clk_i);
      ctl_write_i = 1'b0;
      ctl_read_i = 1'b0;
      v = ctl_readdata_o;
   endtask : ctl

   task automatic tf(input logic w, input logic [3:0] ad, input logic [15:0] d);
      int n;
      @(negedge clk_i);
      tf_address_i = ad;
      tf_writedata_i = d;
      tf_write_i = w;
      tf_read_i = !w;
      n = 0;
      while (tf_waitrequest_o !== 1'b0 && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      v = {16'h0, tf_readdata_o};
      @(negedge clk_i);
      tf_write_i = 1'b0;
      tf_read_i = 1'b0;
      chk(n < 300, 32'h1);
   endtask : tf

   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Clock and watchdog
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #200us;
      failures++;
      final_report();
   end

   // Main sequence
   initial begin
      {rst_i, ce_i, card_detect_i} = 3'h7;
      {tf_read_i, tf_write_i, ctl_read_i, ctl_write_i, card_intrq_i} = 5'h0;
      {tf_address_i, ctl_address_i, tf_writedata_i} = 22'h0;
      ctl_writedata_i = 32'h0;
      repeat (3) @(negedge clk_i);
      chk({card_power_o, card_reset_n_o, tf_waitrequest_o, card_cs_n_o}, 32'h7);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      ctl(1'b0, 2'h0, 32'h0);
      chk(v, 32'h5);
      $display("test reset done");
      foreach (rows[i]) begin
         ctl(1'b1, rows[i].a, rows[i].wd);
         ctl(1'b0, rows[i].a, 32'h0);
         chk(v, rows[i].rd);
         chk({card_power_o, card_reset_n_o}, rows[i].pins);
      end
      $display("test control rows done");
      for (int i = 0; i < 9; i++) begin
         a = (i == 8) ? TF_ALT_STATUS : 4'(i);
         tf(1'b1, a, 16'ha5c0 + 16'(i));
      end
      for (int i = 0; i < 9; i++) begin
         a = (i == 8) ? TF_ALT_STATUS : 4'(i);
         tf(1'b0, a, 16'h0);
         chk(v, (a == 4'h7 || a == 4'he) ? ST : 16'ha5c0 + 16'(i));
      end
      chk(devctl, 16'ha5c8);
      tf(1'b0, 4'h9, 16'h0);
      chk(v, 32'h0);
      $display("test task file done");
      ctl(1'b1, 2'h0, 32'ha);
      for (int k = 0; k < 2; k++) begin
         card_detect_i = k[0];
         repeat (8) @(negedge clk_i);
         chk(presence_irq_o, 32'h1);
         ctl(1'b0, 2'h0, 32'h0);
         chk(v, 32'ha + 32'(k));
         chk(presence_irq_o, 32'h0);
      end
      ctl(1'b1, 2'h0, 32'h2);
      card_detect_i = 1'b0;
      repeat (8) @(negedge clk_i);
      chk(presence_irq_o, 32'h0);
      card_detect_i = 1'b1;
      repeat (8) @(negedge clk_i);
      $display("test presence irq done");
      ctl(1'b1, 2'h1, 32'h1);
      card_intrq_i = 1'b1;
      repeat (10) @(negedge clk_i);
      chk(card_irq_o, 32'h1);
      card_intrq_i = 1'b0;
      repeat (8) @(negedge clk_i);
      ctl(1'b0, 2'h0, 32'h0);
      chk(card_irq_o, 32'h0);
      ctl(1'b1, 2'h1, 32'h0);
      card_intrq_i = 1'b1;
      repeat (10) @(negedge clk_i);
      chk(card_irq_o, 32'h0);
      card_intrq_i = 1'b0;
      repeat (8) @(negedge clk_i);
      $display("test card irq done");
      ce_i = 1'b0;
      ctl(1'b1, 2'h0, 32'h0);
      card_detect_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk({card_power_o, card_reset_n_o}, 32'h3);
      ce_i = 1'b1;
      ctl(1'b0, 2'h0, 32'h0);
      chk(v, 32'h3);
      card_detect_i = 1'b1;
      repeat (8) @(negedge clk_i);
      $display("test clock enable done");
      rst_i = 1'b1;
      @(negedge clk_i);
      chk({card_power_o, card_reset_n_o}, 32'h0);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      ctl(1'b0, 2'h0, 32'h0);
      chk(v, 32'h5);
      $display("test second reset done");
      final_report();
   end
endmodule : cih_host_port_tb_top
`default_nettype wire
